// File: phy_led_pins.sv
// Purpose: led, reset and power-down/interrupt pins of a two-port transceiver
// Assumes: apb slave at 32 bits, rstn asynchronous active low, inputs synchronous
// Notes: strap values are captured on the clock while rstn is low
//
// The APB slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module phy_led_pins import phy_led_pkg::*; #(
  parameter int unsigned BLINK_HALF_CYCLES = BLINK_HALF_CYCLES_DEF,
  parameter int unsigned STRETCH_CYCLES = STRETCH_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic rstn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  // led mode strap
  input wire logic led_mode_strap,
  // port status
  input wire logic [1:0] link_up,
  input wire logic [1:0] speed_100,
  input wire logic [1:0] tx_active,
  input wire logic [1:0] rx_active,
  input wire logic [1:0] collision,
  input wire logic [1:0] full_duplex,
  // led pins, port a
  input wire logic link_indicator_port_a_in,
  output logic link_indicator_port_a_out,
  output logic link_indicator_port_a_oe,
  input wire logic speed_indicator_port_a_in,
  output logic speed_indicator_port_a_out,
  output logic speed_indicator_port_a_oe,
  input wire logic activity_collision_indicator_port_a_in,
  output logic activity_collision_indicator_port_a_out,
  output logic activity_collision_indicator_port_a_oe,
  // led pins, port b
  input wire logic link_indicator_port_b_in,
  output logic link_indicator_port_b_out,
  output logic link_indicator_port_b_oe,
  input wire logic speed_indicator_port_b_in,
  output logic speed_indicator_port_b_out,
  output logic speed_indicator_port_b_oe,
  input wire logic activity_collision_indicator_port_b_in,
  output logic activity_collision_indicator_port_b_out,
  output logic activity_collision_indicator_port_b_oe,
  // power-down / interrupt pins
  input wire logic powerdown_irq_pin_port_a_in,
  output logic powerdown_irq_pin_port_a_out,
  output logic powerdown_irq_pin_port_a_oe,
  input wire logic powerdown_irq_pin_port_b_in,
  output logic powerdown_irq_pin_port_b_out,
  output logic powerdown_irq_pin_port_b_oe,
  output logic [1:0] powerdown
);

  localparam logic [TIMER_W-1:0] BLINK_LAST = TIMER_W'(BLINK_HALF_CYCLES - 1);
  localparam logic [RESET_CNT_W-1:0] RESET_LAST = RESET_CNT_W'(RESET_MIN_CYCLES - 1);

  // strap captures, held after reset release
  logic mode_strap_q;
  logic [2:0] pol_a_q; // link, speed, third
  logic [2:0] pol_b_q;
  logic [RESET_CNT_W-1:0] rst_cnt_q; // cycles rstn has been low
  logic rst_long_q; // last reset met the minimum width

  // registers
  logic [3:0] ctrl_q;
  logic [STAT_W-1:0] status_q;
  logic [STAT_W-1:0] status_d;
  logic [STAT_W-1:0] mask_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic irq_q;

  // port pin state
  logic [1:0] link_prev_q; // for link change events
  logic [1:0] pd_q; // power-down level to the port
  logic [1:0] pin_oe_q; // open-drain pull-down enable
  logic [1:0] pin_in;
  logic [1:0] irq_func;
  logic [1:0] pd_d;
  logic [1:0] port_irq;
  logic [STAT_W-1:0] events;

  // blink timer shared by both ports
  logic [TIMER_W-1:0] blink_cnt_q;
  logic blink_q;

  // bus decode
  logic apb_setup;
  logic apb_done;
  logic status_read;
  led_mode_t mode;

  // word hit at a register offset
  function automatic logic addr_hit(input logic [31:0] addr, input logic [11:0] offset);
    addr_hit = (addr[31:12] == 20'h00000) && (addr[11:0] == offset);
  endfunction : addr_hit

  // straps sampled on the clock while in reset, no async reset on purpose:
  // an async reset would force constants and lose the pin levels
  always_ff @(posedge clk) begin
    if (!rstn) begin
      mode_strap_q <= led_mode_strap;
      pol_a_q <= {activity_collision_indicator_port_a_in, speed_indicator_port_a_in,
                  link_indicator_port_a_in};
      pol_b_q <= {activity_collision_indicator_port_b_in, speed_indicator_port_b_in,
                  link_indicator_port_b_in};
      if (rst_cnt_q != RESET_LAST) begin
        rst_cnt_q <= rst_cnt_q + 1'b1;
      end
      rst_long_q <= (rst_cnt_q == RESET_LAST);
    end else begin
      rst_cnt_q <= '0;
    end
  end

  // mode: register overrides strap with mode three
  always_comb begin
    if (ctrl_q[CTRL_MODE3_BIT]) begin
      mode = MODE_THREE;
    end else if (mode_strap_q) begin
      mode = MODE_TWO;
    end else begin
      mode = MODE_ONE;
    end
  end

  // apb phases; slave answers with one wait-free access cycle
  assign apb_setup = psel && !penable;
  assign apb_done = psel && penable && pready_q;
  assign status_read = apb_done && !pwrite && addr_hit(paddr, STATUS_OFFSET);

  // ready and read data prepared in the setup cycle
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= apb_setup;
      if (apb_setup) begin
        pslverr_q <= !(addr_hit(paddr, CTRL_OFFSET) || addr_hit(paddr, STATUS_OFFSET) ||
                       addr_hit(paddr, MASK_OFFSET) || addr_hit(paddr, STATE_OFFSET));
        if (pwrite) begin
          prdata_q <= 32'h00000000;
        end else if (addr_hit(paddr, CTRL_OFFSET)) begin
          prdata_q <= {28'h0000000, ctrl_q};
        end else if (addr_hit(paddr, STATUS_OFFSET)) begin
          prdata_q <= {28'h0000000, status_q};
        end else if (addr_hit(paddr, MASK_OFFSET)) begin
          prdata_q <= {28'h0000000, mask_q};
        end else if (addr_hit(paddr, STATE_OFFSET)) begin
          prdata_q <= {26'h0000000, rst_long_q, link_up, pd_q, mode_strap_q};
        end else begin
          prdata_q <= 32'h00000000; // unmapped reads zero with error
        end
      end
    end
  end

  // writable registers
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ctrl_q <= CTRL_RESET;
      mask_q <= MASK_RESET;
    end else if (apb_done && pwrite) begin
      if (addr_hit(paddr, CTRL_OFFSET)) begin
        ctrl_q <= pwdata[3:0];
      end
      if (addr_hit(paddr, MASK_OFFSET)) begin
        mask_q <= pwdata[STAT_W-1:0];
      end
    end
  end

  // pin function: power-down input unless software picked interrupt
  assign irq_func = ctrl_q[CTRL_IRQ_FUNC_LSB +: 2];
  assign pin_in = {powerdown_irq_pin_port_b_in, powerdown_irq_pin_port_a_in};
  assign pd_d = ~irq_func & ~pin_in;
  assign events[STAT_LINK_LSB +: 2] = link_up ^ link_prev_q;
  assign events[STAT_PD_LSB +: 2] = pd_d & ~pd_q;

  // only the bits already returned are cleared, so a set wins over the clear
  always_comb begin
    status_d = status_q;
    if (status_read) begin
      status_d = status_q & ~prdata_q[STAT_W-1:0];
    end
    status_d = status_d | events;
  end

  // sticky status and interrupt level
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status_q <= STAT_RESET;
      irq_q <= 1'b0;
    end else begin
      status_q <= status_d;
      irq_q <= |(status_d & mask_q);
    end
  end

  // per-port interrupt condition from that port's unmasked bits
  assign port_irq[0] = status_q[STAT_LINK_LSB] & mask_q[STAT_LINK_LSB] |
                       status_q[STAT_PD_LSB] & mask_q[STAT_PD_LSB];
  assign port_irq[1] = status_q[STAT_LINK_LSB+1] & mask_q[STAT_LINK_LSB+1] |
                       status_q[STAT_PD_LSB+1] & mask_q[STAT_PD_LSB+1];

  // independent pin logic for each port
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      link_prev_q <= 2'h0;
      pd_q <= 2'h0;
      pin_oe_q <= 2'h0;
    end else begin
      for (int p = 0; p < 2; p++) begin
        link_prev_q[p] <= link_up[p];
        pd_q[p] <= pd_d[p];
        pin_oe_q[p] <= irq_func[p] && port_irq[p];
      end
    end
  end

  // blink phase for link lights
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      blink_cnt_q <= '0;
      blink_q <= 1'b0;
    end else if (blink_cnt_q == BLINK_LAST) begin
      blink_cnt_q <= '0;
      blink_q <= !blink_q;
    end else begin
      blink_cnt_q <= blink_cnt_q + 1'b1;
    end
  end

  // port a leds
  led_port #(.STRETCH_CYCLES(STRETCH_CYCLES)) port_a_leds (
    .clk(clk),
    .rstn(rstn),
    .mode(mode),
    .dup_sel(ctrl_q[CTRL_DUPLEX_BIT]),
    .blink(blink_q),
    .pol_link(pol_a_q[0]),
    .pol_speed(pol_a_q[1]),
    .pol_act(pol_a_q[2]),
    .link_up(link_up[0]),
    .speed_100(speed_100[0]),
    .tx_active(tx_active[0]),
    .rx_active(rx_active[0]),
    .collision(collision[0]),
    .full_duplex(full_duplex[0]),
    .link_out_q(link_indicator_port_a_out),
    .speed_out_q(speed_indicator_port_a_out),
    .act_out_q(activity_collision_indicator_port_a_out),
    .led_oe_q(link_indicator_port_a_oe)
  );

  // port b leds
  led_port #(.STRETCH_CYCLES(STRETCH_CYCLES)) port_b_leds (
    .clk(clk),
    .rstn(rstn),
    .mode(mode),
    .dup_sel(ctrl_q[CTRL_DUPLEX_BIT]),
    .blink(blink_q),
    .pol_link(pol_b_q[0]),
    .pol_speed(pol_b_q[1]),
    .pol_act(pol_b_q[2]),
    .link_up(link_up[1]),
    .speed_100(speed_100[1]),
    .tx_active(tx_active[1]),
    .rx_active(rx_active[1]),
    .collision(collision[1]),
    .full_duplex(full_duplex[1]),
    .link_out_q(link_indicator_port_b_out),
    .speed_out_q(speed_indicator_port_b_out),
    .act_out_q(activity_collision_indicator_port_b_out),
    .led_oe_q(link_indicator_port_b_oe)
  );

  // all three pins of a port share one drive enable flop
  assign speed_indicator_port_a_oe = link_indicator_port_a_oe;
  assign activity_collision_indicator_port_a_oe = link_indicator_port_a_oe;
  assign speed_indicator_port_b_oe = link_indicator_port_b_oe;
  assign activity_collision_indicator_port_b_oe = link_indicator_port_b_oe;

  // open drain: data is always low, only the enable moves
  assign powerdown_irq_pin_port_a_out = 1'b0;
  assign powerdown_irq_pin_port_b_out = 1'b0;
  assign powerdown_irq_pin_port_a_oe = pin_oe_q[0];
  assign powerdown_irq_pin_port_b_oe = pin_oe_q[1];
  assign powerdown = pd_q;

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign irq = irq_q;

  // strap level in reset is what the mode decode sees afterwards
  strap_capture_a: assert property (@(posedge clk)
    !rstn |=> mode_strap_q == $past(led_mode_strap))
    else $error("led mode strap not captured");

  // pin low in power-down function reaches power-down next cycle
  pd_follow_a: assert property (@(posedge clk) disable iff (!rstn)
    !irq_func[0] && !pin_in[0] |=> pd_q[0])
    else $error("port a power-down not entered");

  // power-down function never drives the pin
  pd_release_a: assert property (@(posedge clk) disable iff (!rstn)
    !irq_func[1] |=> !pin_oe_q[1] && (pd_q[1] == $past(!pin_in[1])))
    else $error("port b pin driven in power-down function");

  // interrupt function pulls the pin while the port interrupt stands
  irq_pull_a: assert property (@(posedge clk) disable iff (!rstn)
    irq_func[0] && port_irq[0] |=> pin_oe_q[0] && !powerdown_irq_pin_port_a_out)
    else $error("interrupt pin not pulled low");

  // event arriving during a status read still lands
  event_kept_a: assert property (@(posedge clk) disable iff (!rstn)
    events[STAT_LINK_LSB+1] |=> status_q[STAT_LINK_LSB+1])
    else $error("link event lost");

endmodule : phy_led_pins

// File: phy_led_pkg.sv
// Purpose: shared constants for the led, reset and power-down pin block
// Assumes: 200 MHz system clock, 32-bit apb register bus
// Notes: times are kept in their own unit; cycle counts derive from them
package phy_led_pkg;

  // clock period in ns
  localparam int unsigned CLK_PERIOD_NS = 5;

  // least reset pulse width in us, rounded up to whole cycles
  localparam int unsigned RESET_MIN_US = 1;
  localparam int unsigned RESET_MIN_CYCLES =
    (RESET_MIN_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RESET_CNT_W = 8;

  // blink half period and activity stretch, in ms
  localparam int unsigned BLINK_HALF_MS = 50;
  localparam int unsigned BLINK_HALF_CYCLES_DEF = BLINK_HALF_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned STRETCH_MS = 30;
  localparam int unsigned STRETCH_CYCLES_DEF = STRETCH_MS * 1000000 / CLK_PERIOD_NS;
  localparam int unsigned TIMER_W = 24;

  // register byte offsets
  localparam logic [11:0] CTRL_OFFSET = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;
  localparam logic [11:0] MASK_OFFSET = 12'h008;
  localparam logic [11:0] STATE_OFFSET = 12'h00C;

  // control fields
  localparam int unsigned CTRL_MODE3_BIT = 0;
  localparam int unsigned CTRL_DUPLEX_BIT = 1;
  localparam int unsigned CTRL_IRQ_FUNC_LSB = 2;
  localparam logic [3:0] CTRL_RESET = 4'h0;

  // status and mask fields: link change a/b, power-down request a/b
  localparam int unsigned STAT_LINK_LSB = 0;
  localparam int unsigned STAT_PD_LSB = 2;
  localparam int unsigned STAT_W = 4;
  localparam logic [3:0] STAT_RESET = 4'h0;
  localparam logic [3:0] MASK_RESET = 4'h0;

  // state register fields
  localparam int unsigned STATE_STRAP_BIT = 0;
  localparam int unsigned STATE_PD_LSB = 1;
  localparam int unsigned STATE_LINK_LSB = 3;
  localparam int unsigned STATE_RSTOK_BIT = 5;

  // led operating modes
  typedef enum logic [1:0] {MODE_ONE, MODE_TWO, MODE_THREE} led_mode_t;

endpackage : phy_led_pkg

// File: led_port.sv
// Purpose: three led pins of one port, with blink and stretch
// Assumes: status inputs synchronous to clk
// Notes: pins stay released during reset so straps can be read
`timescale 1ns/1ps
module led_port import phy_led_pkg::*; #(
  parameter int unsigned STRETCH_CYCLES = STRETCH_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic rstn,
  input wire led_mode_t mode,
  input wire logic dup_sel,
  input wire logic blink,
  input wire logic pol_link,
  input wire logic pol_speed,
  input wire logic pol_act,
  input wire logic link_up,
  input wire logic speed_100,
  input wire logic tx_active,
  input wire logic rx_active,
  input wire logic collision,
  input wire logic full_duplex,
  output logic link_out_q,
  output logic speed_out_q,
  output logic act_out_q,
  output logic led_oe_q
);

  localparam logic [TIMER_W-1:0] STRETCH_LOAD = TIMER_W'(STRETCH_CYCLES);

  logic [TIMER_W-1:0] act_cnt_q; // activity stretch timer
  logic [TIMER_W-1:0] col_cnt_q; // collision stretch timer
  logic act_on; // activity seen now or lately
  logic col_on; // collision seen now or lately
  logic link_on;
  logic third_on;

  // a pulled-up pin lights its led by driving low
  function automatic logic led_level(input logic on, input logic pol);
    led_level = on ^ pol;
  endfunction : led_level

  // short activity would be invisible, so hold it for a fixed time
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      act_cnt_q <= '0;
      col_cnt_q <= '0;
    end else begin
      if (tx_active || rx_active) begin
        act_cnt_q <= STRETCH_LOAD;
      end else if (act_cnt_q != '0) begin
        act_cnt_q <= act_cnt_q - 1'b1;
      end
      if (collision) begin
        col_cnt_q <= STRETCH_LOAD;
      end else if (col_cnt_q != '0) begin
        col_cnt_q <= col_cnt_q - 1'b1;
      end
    end
  end

  assign act_on = tx_active || rx_active || (act_cnt_q != '0);
  assign col_on = collision || (col_cnt_q != '0);

  // per-mode led meaning
  always_comb begin
    link_on = 1'b0;
    third_on = 1'b0;
    case (mode)
      MODE_ONE: begin
        link_on = link_up;
        third_on = act_on;
      end
      MODE_TWO: begin
        link_on = link_up && (!act_on || blink);
        third_on = col_on;
      end
      MODE_THREE: begin
        link_on = link_up && (!act_on || blink);
        third_on = dup_sel ? full_duplex : col_on;
      end
      default: begin
        link_on = 1'b0;
        third_on = 1'b0;
      end
    endcase
  end

  // pin drivers, released while in reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      link_out_q <= 1'b0;
      speed_out_q <= 1'b0;
      act_out_q <= 1'b0;
      led_oe_q <= 1'b0;
    end else begin
      link_out_q <= led_level(link_on, pol_link);
      speed_out_q <= led_level(speed_100, pol_speed);
      act_out_q <= led_level(third_on, pol_act);
      led_oe_q <= 1'b1;
    end
  end

  // speed light ignores mode
  speed_led_a: assert property (@(posedge clk) disable iff (!rstn)
    led_oe_q |-> speed_out_q == ($past(speed_100) ^ pol_speed))
    else $error("speed led does not follow speed");

  // mode one link light is plain link state
  link_plain_a: assert property (@(posedge clk) disable iff (!rstn)
    $past(mode) == MODE_ONE && led_oe_q |-> link_out_q == ($past(link_up) ^ pol_link))
    else $error("link led wrong in mode one");

  // activity mode one lit during traffic
  act_lit_a: assert property (@(posedge clk) disable iff (!rstn)
    $past(mode) == MODE_ONE && $past(tx_active || rx_active) && led_oe_q
    |-> act_out_q == !pol_act)
    else $error("activity led not lit");

  // link down keeps link light off in blinking modes
  link_dark_a: assert property (@(posedge clk) disable iff (!rstn)
    $past(mode) != MODE_ONE && !$past(link_up) && led_oe_q |-> link_out_q == pol_link)
    else $error("link led lit without link");

  // mode two third light shows collision
  col_lit_a: assert property (@(posedge clk) disable iff (!rstn)
    $past(mode) == MODE_TWO && $past(collision) && led_oe_q |-> act_out_q == !pol_act)
    else $error("collision led not lit");

  // mode three duplex select shows duplex
  duplex_led_a: assert property (@(posedge clk) disable iff (!rstn)
    $past(mode) == MODE_THREE && $past(dup_sel) && led_oe_q
    |-> act_out_q == ($past(full_duplex) ^ pol_act))
    else $error("duplex led wrong");

endmodule : led_port

// File: led_host_model.sv
// Purpose: led pull resistors and host side of the power-down pins
// Assumes: a released line settles at its pull level
// Notes: port a leds pulled low, port b leds pulled high
`timescale 1ns/1ps
module led_host_model (
  input wire logic [5:0] led_out,
  input wire logic [5:0] led_oe,
  input wire logic [1:0] pd_oe,
  input wire logic [1:0] host_pd_low,
  output logic [5:0] led_line,
  output logic [1:0] pd_line
);
  // strap pulls: bits 0..2 port a, 3..5 port b
  localparam logic [5:0] PULL = 6'h38;
  // released led line shows its pull, so the strap is read in reset
  assign led_line = (led_oe & led_out) | (~led_oe & PULL);
  // open drain with pull-up: host or device low wins
  assign pd_line = ~(pd_oe | host_pd_low);
endmodule : led_host_model

// File: tb_top.sv
// Purpose: self-checking bench for the led and power-down pin block
// Assumes: apb master tasks, short blink and stretch parameters
// Notes: expected led levels are the lit pattern xor the pulls
`timescale 1ns/1ps
module tb_top;
  import phy_led_pkg::*;
  localparam int unsigned BH = 8;
  localparam int unsigned SC = 4;
  localparam logic [5:0] PULL = 6'h38;
  logic clk = 1'h0, rstn = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
  logic strap = 1'h0, pready, pslverr, irq, se;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rd;
  logic [1:0] link = 2'h0, spd = 2'h0, tx = 2'h0, rx = 2'h0, col = 2'h0, fdx = 2'h0;
  logic [1:0] pd_low = 2'h0, pd_oe, pd_out, pwd, pdl;
  logic [5:0] lo, le, ll;
  int err_count = 0, samples_checked = 0, n;
  // 200 MHz clock
  always #2.5 clk = ~clk;
  phy_led_pins #(.BLINK_HALF_CYCLES(BH), .STRETCH_CYCLES(SC)) phy_led_pins_i (
    .clk(clk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .irq(irq), .led_mode_strap(strap), .link_up(link),
    .speed_100(spd), .tx_active(tx), .rx_active(rx), .collision(col),
    .full_duplex(fdx), .link_indicator_port_a_in(ll[0]),
    .link_indicator_port_a_out(lo[0]), .link_indicator_port_a_oe(le[0]),
    .speed_indicator_port_a_in(ll[1]), .speed_indicator_port_a_out(lo[1]),
    .speed_indicator_port_a_oe(le[1]), .activity_collision_indicator_port_a_in(ll[2]),
    .activity_collision_indicator_port_a_out(lo[2]),
    .activity_collision_indicator_port_a_oe(le[2]), .link_indicator_port_b_in(ll[3]),
    .link_indicator_port_b_out(lo[3]), .link_indicator_port_b_oe(le[3]),
    .speed_indicator_port_b_in(ll[4]), .speed_indicator_port_b_out(lo[4]),
    .speed_indicator_port_b_oe(le[4]), .activity_collision_indicator_port_b_in(ll[5]),
    .activity_collision_indicator_port_b_out(lo[5]),
    .activity_collision_indicator_port_b_oe(le[5]),
    .powerdown_irq_pin_port_a_in(pdl[0]), .powerdown_irq_pin_port_a_out(pd_out[0]),
    .powerdown_irq_pin_port_a_oe(pd_oe[0]), .powerdown_irq_pin_port_b_in(pdl[1]),
    .powerdown_irq_pin_port_b_out(pd_out[1]), .powerdown_irq_pin_port_b_oe(pd_oe[1]),
    .powerdown(pwd)
  );
  led_host_model led_host_model_i (.led_out(lo), .led_oe(le), .pd_oe(pd_oe),
    .host_pd_low(pd_low), .led_line(ll), .pd_line(pdl));
  // verdict and end of run
  task automatic conclude;
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : conclude
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask : cyc
  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int i;
    @(posedge clk);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'h1 && i < 20);
    if (i >= 20) begin
      chk("apb wait", 32'h1, 32'h0);
      conclude();
    end else begin
      rd = prdata;
      se = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
    end
  endtask : apb
  // reset held k cycles with the mode strap at s
  task automatic rst(input int k, input logic s);
    @(posedge clk);
    strap <= s;
    rstn <= 1'h0;
    cyc(k);
    rstn <= 1'h1;
    cyc(2);
  endtask : rst
  initial begin
    cyc(1);
    rst(16, 1'h0);
    apb(1'h0, {20'h0, STATE_OFFSET}, 32'h0);
    chk("short reset", rd[5], 32'h0);
    chk("leds driven", le, 32'h3F);
    chk("pd pin free", pd_oe, 32'h0);
    apb(1'h0, 32'h10, 32'h0);
    chk("unmapped", se, 32'h1);
    link <= 2'h3;
    spd <= 2'h1;
    cyc(3);
    chk("mode one idle", lo, 6'h0B ^ PULL);
    tx <= 2'h1;
    rx <= 2'h2;
    for (n = 0; n < 3 * BH; n++) begin
      cyc(1);
      if (n > 2) chk("mode one busy", lo, 6'h2F ^ PULL);
    end
    tx <= 2'h0;
    rx <= 2'h0;
    cyc(2);
    chk("stretch on", lo[2], 32'h1);
    cyc(SC + 3);
    chk("stretch off", lo, 6'h0B ^ PULL);
    apb(1'h1, {20'h0, CTRL_OFFSET}, 32'h3);
    rst(210, 1'h1);
    apb(1'h0, {20'h0, STATE_OFFSET}, 32'h0);
    chk("strap again", rd[5:0], 32'h39);
    apb(1'h0, {20'h0, CTRL_OFFSET}, 32'h0);
    chk("ctrl reset", rd, 32'h0);
    apb(1'h0, {20'h0, MASK_OFFSET}, 32'h0);
    chk("mask reset", rd, 32'h0);
    col <= 2'h1;
    cyc(3);
    chk("collision", lo[2], 32'h1);
    col <= 2'h0;
    tx <= 2'h1;
    cyc(2);
    n = 0;
    repeat (4 * BH) begin
      @(posedge clk);
      n = n + lo[0];
    end
    chk("blink", n, 2 * BH);
    chk("link b steady", lo[3], 32'h0);
    apb(1'h1, {20'h0, CTRL_OFFSET}, 32'h3);
    tx <= 2'h0;
    fdx <= 2'h1;
    col <= 2'h2;
    cyc(SC + 4);
    chk("duplex", {lo[5], lo[2]}, 32'h1 ^ {PULL[5], PULL[2]});
    fdx <= 2'h0;
    cyc(3);
    chk("duplex off", lo[2], 32'h0);
    apb(1'h1, {20'h0, CTRL_OFFSET}, 32'h1);
    cyc(3);
    chk("mode three col", lo[5], 32'h0);
    col <= 2'h0;
    pd_low <= 2'h1;
    cyc(3);
    chk("powerdown", pwd, 32'h1);
    chk("masked", irq, 32'h0);
    pd_low <= 2'h0;
    cyc(2);
    chk("powerup", pwd, 32'h0);
    apb(1'h0, {20'h0, STATUS_OFFSET}, 32'h0);
    chk("pd event", rd[2], 32'h1);
    apb(1'h1, {20'h0, MASK_OFFSET}, 32'h1);
    apb(1'h1, {20'h0, CTRL_OFFSET}, 32'h4);
    cyc(2);
    chk("no irq yet", {irq, pd_oe}, 32'h0);
    link <= 2'h2;
    cyc(3);
    chk("irq pin", {irq, pd_oe, pdl}, 32'h16);
    chk("od data", pd_out, 32'h0);
    chk("pin ignored", pwd, 32'h0);
    apb(1'h0, {20'h0, STATUS_OFFSET}, 32'h0);
    chk("link event", rd[0], 32'h1);
    cyc(2);
    chk("irq clear", {irq, pd_oe, pdl}, 32'h3);
    apb(1'h1, {20'h0, MASK_OFFSET}, 32'h2);
    apb(1'h1, {20'h0, CTRL_OFFSET}, 32'h8);
    link <= 2'h0;
    cyc(3);
    chk("irq pin b", {irq, pd_oe, pdl}, 32'h19);
    chk("pin b ignored", pwd, 32'h0);
    conclude();
  end
endmodule : tb_top
